// >>> tx_ctrl_pkg.sv
package tx_ctrl_pkg;
  localparam int unsigned CLK_HZ                = 100_000_000;
  localparam int unsigned TICK_US               = 1000;
  localparam int unsigned TICK_CYCLES           = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned RESTART_PERIOD_S      = 5;
  localparam int unsigned RESTART_PERIOD_TICKS  = RESTART_PERIOD_S * 1_000_000 / TICK_US;
  localparam int unsigned RESTART_TIMEOUT_S     = 30;
  localparam int unsigned RESTART_TIMEOUT_TICKS = RESTART_TIMEOUT_S * 1_000_000 / TICK_US;
  localparam int unsigned DECAY_MIN             = 30;
  localparam int unsigned DECAY_STEP_TICKS      =
    DECAY_MIN * 60 * (1_000_000 / TICK_US) / RESTART_TIMEOUT_TICKS;
  localparam int unsigned RESTART_PULSE_MS      = 10;
  localparam int unsigned RESTART_PULSE_TICKS   = RESTART_PULSE_MS * 1000 / TICK_US;
  localparam int unsigned DEBOUNCE_MS           = 20;
  localparam int unsigned DEBOUNCE_TICKS        = DEBOUNCE_MS * 1000 / TICK_US;
  localparam int unsigned SAMPLE_W              = 12;
  localparam int unsigned FAULT_THRESHOLD_MV    = 2250;
  localparam logic [11:0] FAULT_THRESHOLD       = 12'(FAULT_THRESHOLD_MV);
  localparam int unsigned STEP_W                = 6;
  localparam logic [5:0]  STEP_MAX              = 6'h3F;
  localparam logic [5:0]  STEP_RST              = 6'h00;
  localparam logic [7:0]  CTRL_OFS              = 8'h00;
  localparam logic [7:0]  CMD_OFS               = 8'h04;
  localparam logic [7:0]  STATUS_OFS            = 8'h08;
  localparam logic [7:0]  IDLE_MAX_OFS          = 8'h0C;
  localparam logic [7:0]  MAX_ANALOG_OFS        = 8'h10;
  localparam logic [7:0]  MAX_HYBRID_OFS        = 8'h14;
  localparam logic [7:0]  MAX_DIGITAL_OFS       = 8'h18;
  localparam logic [1:0]  CTRL_RST              = 2'h0;
  localparam logic [7:0]  IDLE_MAX_RST          = 8'h80;
  localparam logic [7:0]  MODE_MAX_RST          = 8'hFF;
  localparam int unsigned CTRL_REMOTE_EN_BIT    = 0;
  localparam int unsigned CTRL_MUTE_BIT         = 1;
  localparam int unsigned CMD_ON_BIT            = 0;
  localparam int unsigned CMD_OFF_BIT           = 1;
  localparam int unsigned CMD_RAISE_BIT         = 2;
  localparam int unsigned CMD_LOWER_BIT         = 3;
  localparam int unsigned SYNC_W                = 13;

  typedef enum logic [1:0] {MOD_OFF, MOD_ON, MOD_RESET} module_cmd_e;

  typedef struct packed {
    logic on;
    logic off;
    logic raise;
    logic lower;
  } buttons_s;

  typedef struct packed {
    logic analog_only;
    logic hybrid;
    logic digital_or_split;
  } mode_s;
endpackage

// >>> input_sync.sv
`timescale 1ns/1ps
module input_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // A change is accepted once stages two and three agree, so a late edge is never half-seen.
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (rst) begin
          level[i] <= 1'b0;
        end else if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  endgenerate
endmodule

// >>> button_debounce.sv
`timescale 1ns/1ps
module button_debounce #(
  parameter int unsigned TICKS = 20
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic tick,
  input  wire logic pressed,
  output logic      press_pulse
);
  logic [15:0] count;
  logic        stable;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count <= 16'h0000;
      stable <= 1'b0;
    end else if (pressed == stable) begin
      count <= 16'h0000;
    end else if (tick) begin
      if (count >= 16'(TICKS - 1)) begin
        count <= 16'h0000;
        stable <= pressed;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      press_pulse <= 1'b0;
    end else begin
      press_pulse <= tick && pressed && !stable && (count >= 16'(TICKS - 1));
    end
  end
endmodule

// >>> tx_controller.sv
// Overview of operation
// - A broken external interlock forces the stored on state off.
// - Load over-temperature above 125 C also forces the transmitter off.
// - Off-status flag follows the off state, is reported, and zeroes power control.
// - Restart pulses go to the power modules about every five seconds.
// - Pulses need on, modules off, mains good, interlock good, no timeout.
// - Attempt time accumulates while pulses are called; thirty seconds latches timeout.
// - Without restart demand or a latched timeout, accumulated attempt time decays to empty in thirty minutes.
// - Any on command clears the accumulator; it clears the timeout fault unless the limit is reached in the same cycle.
// - Power setting has 64 logarithmic steps; raise and lower move one step.
// - Panel raise/lower always work; remote ones only with remote enabled.
// - An active mute request forces power control to zero.
// - Carrier status lines decode to analog, hybrid or digital/split mode.
// - Neither carrier present maps to the digital/split mode.
// - One-hot mode outputs pick setpoint, meter calibration and indicator.
// - Class C bias in analog-only mode, zero bias in other modes.
// - Bias shift switch off keeps zero bias even in analog-only mode.
// - Forward sample below threshold flags low gain; reverse above flags foldback.
// - Any PA module shutdown clamps power control to the idle maximum.
// - Module command is off, on, or reset that clears module faults.
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module tx_controller
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned TICK         = tx_ctrl_pkg::TICK_CYCLES,
  parameter int unsigned PERIOD_TICKS = tx_ctrl_pkg::RESTART_PERIOD_TICKS,
  parameter int unsigned TIMEOUT_TKS  = tx_ctrl_pkg::RESTART_TIMEOUT_TICKS
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire logic                  interlock_fault,
  input  wire logic                  load_overtemp,
  input  wire logic                  mains_fault,
  input  wire logic                  pa_volts_present,
  input  wire logic                  module_shutdown,
  input  wire logic                  analog_carrier_present_n,
  input  wire logic                  digital_carrier_present_n,
  input  wire logic                  exciter_mute,
  input  wire logic                  bias_shift_enable_switch,
  input  wire tx_ctrl_pkg::buttons_s panel_buttons,
  input  wire logic [11:0]           fwd_sample,
  input  wire logic [11:0]           rev_sample,
  output tx_ctrl_pkg::module_cmd_e   module_cmd,
  output logic                       tx_off_status,
  output logic                       restart_fault,
  output logic [7:0]                 power_control_level,
  output tx_ctrl_pkg::mode_s         mode,
  output logic                       pa_bias_class_c,
  output logic                       low_gain_fault,
  output logic                       foldback_fault
);
  import tx_ctrl_pkg::*;

  logic [SYNC_W-1:0] sync_level;
  buttons_s          pb;
  buttons_s          rcmd;
  buttons_s          cmd_wr;
  logic              s_ilock;
  logic              s_overtemp;
  logic              s_mains;
  logic              s_pa_volts;
  logic              s_shutdown;
  logic              s_analog_n;
  logic              s_digital_n;
  logic              s_mute;
  logic              s_bias_sw;
  logic [31:0]       tick_cnt;
  logic              tick;
  logic              tx_on;
  logic [1:0]        ctrl;
  logic [7:0]        idle_max;
  logic [7:0]        mode_max [3];
  logic [5:0]        power_step;
  logic              on_cmd;
  logic              off_cmd;
  logic              raise_cmd;
  logic              lower_cmd;
  logic              restart_call;
  logic [31:0]       period_cnt;
  logic [15:0]       pulse_cnt;
  logic [31:0]       accum;
  logic [15:0]       decay_cnt;
  logic              wr_pend;
  logic [7:0]        wr_ofs;
  logic [31:0]       next_rdata;
  logic [7:0]        sel_max;
  logic [15:0]       product;
  logic [7:0]        next_level;

  // Decodes the word offset of a bus address; shared by the read and write paths.
  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    return {a[7:2], 2'b00};
  endfunction

  // Log weighting: the top 16 steps are 8 apart, each lower group halves that spacing.
  function automatic logic [7:0] step_weight(input logic [5:0] s);
    logic [5:0] d;
    logic [7:0] base;
    d = STEP_MAX - s;
    base = 8'hFF - {1'b0, d[3:0], 3'h0};
    if (s == 6'h00) begin
      return 8'h00;
    end
    return base >> d[5:4];
  endfunction

  input_sync #(
    .W (SYNC_W)
  ) u_sync (
    .mclk  (mclk),
    .rst   (rst),
    .raw   ({interlock_fault, load_overtemp, mains_fault, pa_volts_present,
             module_shutdown, analog_carrier_present_n, digital_carrier_present_n,
             exciter_mute, bias_shift_enable_switch, panel_buttons}),
    .level (sync_level)
  );

  assign {s_ilock, s_overtemp, s_mains, s_pa_volts, s_shutdown, s_analog_n,
          s_digital_n, s_mute, s_bias_sw} = sync_level[SYNC_W-1:4];

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_button
      button_debounce #(
        .TICKS (DEBOUNCE_TICKS)
      ) u_db (
        .mclk        (mclk),
        .rst         (rst),
        .tick        (tick),
        .pressed     (sync_level[b]),
        .press_pulse (pb[b])
      );
    end
  endgenerate

  // Millisecond tick keeps the long timers narrow.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (tick_cnt >= 32'(TICK - 1)) begin
      tick_cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end

  // Remote commands are write pulses; they only count while remote control is enabled.
  assign rcmd = ctrl[CTRL_REMOTE_EN_BIT] ? cmd_wr : '0;
  assign on_cmd = pb.on || rcmd.on;
  assign off_cmd = pb.off || rcmd.off;
  assign raise_cmd = pb.raise || rcmd.raise;
  assign lower_cmd = pb.lower || rcmd.lower;

  // Shutdown conditions dominate any command, like a hardware override of the latch.
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_on <= 1'b0;
    end else if (s_ilock) begin
      tx_on <= 1'b0;
    end else if (s_overtemp) begin
      tx_on <= 1'b0;
    end else if (off_cmd) begin
      tx_on <= 1'b0;
    end else if (on_cmd) begin
      tx_on <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_off_status <= 1'b1;
    end else begin
      tx_off_status <= !tx_on;
    end
  end

  assign restart_call = tx_on && !s_pa_volts && !s_mains && !s_ilock && !restart_fault;

  // Period counter; a pulse fires each time a full period of demand has passed.
  always_ff @(posedge mclk) begin
    if (rst || !restart_call) begin
      period_cnt <= 32'h00000000;
    end else if (tick) begin
      if (period_cnt >= 32'(PERIOD_TICKS - 1)) begin
        period_cnt <= 32'h00000000;
      end else begin
        period_cnt <= period_cnt + 32'h00000001;
      end
    end
  end

  // An on command also issues a reset pulse, as the panel button does on the real chassis.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pulse_cnt <= 16'h0000;
    end else if (on_cmd || (restart_call && tick && period_cnt >= 32'(PERIOD_TICKS - 1))) begin
      pulse_cnt <= 16'(RESTART_PULSE_TICKS);
    end else if (tick && pulse_cnt != 16'h0000) begin
      pulse_cnt <= pulse_cnt - 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      module_cmd <= MOD_OFF;
    end else if (pulse_cnt != 16'h0000) begin
      module_cmd <= MOD_RESET;
    end else if (tx_on) begin
      module_cmd <= MOD_ON;
    end else begin
      module_cmd <= MOD_OFF;
    end
  end

  // Attempt accumulator: charges while pulses are called, leaks slowly otherwise unless the timeout is latched.
  always_ff @(posedge mclk) begin
    if (rst || on_cmd) begin
      accum <= 32'h00000000;
      decay_cnt <= 16'h0000;
    end else if (restart_call) begin
      decay_cnt <= 16'h0000;
      if (tick && accum < 32'(TIMEOUT_TKS)) begin
        accum <= accum + 32'h00000001;
      end
    end else if (!restart_fault && tick && accum != 32'h00000000) begin
      if (decay_cnt >= 16'(DECAY_STEP_TICKS - 1)) begin
        decay_cnt <= 16'h0000;
        accum <= accum - 32'h00000001;
      end else begin
        decay_cnt <= decay_cnt + 16'h0001;
      end
    end
  end

  // Reaching the limit wins over a simultaneous on command.
  always_ff @(posedge mclk) begin
    if (rst) begin
      restart_fault <= 1'b0;
    end else if (restart_call && accum >= 32'(TIMEOUT_TKS)) begin
      restart_fault <= 1'b1;
    end else if (on_cmd) begin
      restart_fault <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      power_step <= STEP_RST;
    end else if (raise_cmd && !lower_cmd && power_step != STEP_MAX) begin
      power_step <= power_step + 6'h01;
    end else if (lower_cmd && !raise_cmd && power_step != 6'h00) begin
      power_step <= power_step - 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= '{analog_only: 1'b0, hybrid: 1'b0, digital_or_split: 1'b1};
    end else begin
      mode.analog_only <= !s_analog_n && s_digital_n;
      mode.hybrid <= !s_analog_n && !s_digital_n;
      mode.digital_or_split <= s_analog_n;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pa_bias_class_c <= 1'b0;
    end else begin
      pa_bias_class_c <= mode.analog_only && s_bias_sw;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      low_gain_fault <= 1'b0;
      foldback_fault <= 1'b0;
    end else begin
      low_gain_fault <= fwd_sample < FAULT_THRESHOLD;
      foldback_fault <= rev_sample > FAULT_THRESHOLD;
    end
  end

  // The mode's maximum scales the stepped weight, so raise and lower span zero to one below that maximum.
  always_comb begin
    sel_max = mode.analog_only ? mode_max[0] : (mode.hybrid ? mode_max[1] : mode_max[2]);
    product = 16'(step_weight(power_step)) * 16'(sel_max);
    next_level = product[15:8];
    if (s_shutdown && next_level > idle_max) begin
      next_level = idle_max;
    end
    if (tx_off_status || s_mute || ctrl[CTRL_MUTE_BIT]) begin
      next_level = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      power_control_level <= 8'h00;
    end else begin
      power_control_level <= next_level;
    end
  end

  // Zero-wait slave: writes land in the data phase, reads are registered at the address phase.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_ofs <= word_ofs(haddr);
    end
  end

  always_comb begin
    cmd_wr = '0;
    if (wr_pend && wr_ofs == CMD_OFS) begin
      cmd_wr.on = hwdata[CMD_ON_BIT];
      cmd_wr.off = hwdata[CMD_OFF_BIT];
      cmd_wr.raise = hwdata[CMD_RAISE_BIT];
      cmd_wr.lower = hwdata[CMD_LOWER_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      idle_max <= IDLE_MAX_RST;
      mode_max <= '{MODE_MAX_RST, MODE_MAX_RST, MODE_MAX_RST};
    end else if (wr_pend) begin
      case (wr_ofs)
        CTRL_OFS:        ctrl <= hwdata[1:0];
        IDLE_MAX_OFS:    idle_max <= hwdata[7:0];
        MAX_ANALOG_OFS:  mode_max[0] <= hwdata[7:0];
        MAX_HYBRID_OFS:  mode_max[1] <= hwdata[7:0];
        MAX_DIGITAL_OFS: mode_max[2] <= hwdata[7:0];
        default:         ctrl <= ctrl;
      endcase
    end
  end

  always_comb begin
    case (word_ofs(haddr))
      CTRL_OFS:        next_rdata = {30'h0, ctrl};
      STATUS_OFS:      next_rdata = {14'h0, power_step, mode, foldback_fault, low_gain_fault,
                                     s_shutdown, s_ilock, s_overtemp, s_mains, restart_fault,
                                     tx_off_status, tx_on};
      IDLE_MAX_OFS:    next_rdata = {24'h0, idle_max};
      MAX_ANALOG_OFS:  next_rdata = {24'h0, mode_max[0]};
      MAX_HYBRID_OFS:  next_rdata = {24'h0, mode_max[1]};
      MAX_DIGITAL_OFS: next_rdata = {24'h0, mode_max[2]};
      default:         next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= next_rdata;
    end
  end
endmodule

// >>> tx_checker.sv
`timescale 1ns/1ps
module tx_checker
  import tx_ctrl_pkg::*;
#(
  parameter int unsigned TICK         = 4,
  parameter int unsigned PERIOD_TICKS = 5,
  parameter int unsigned TIMEOUT_TKS  = 20
) (
  input wire logic                     mclk,
  input wire logic                     rst,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  input wire logic                     interlock_fault,
  input wire logic                     load_overtemp,
  input wire logic                     analog_carrier_present_n,
  input wire logic                     digital_carrier_present_n,
  input wire logic                     exciter_mute,
  input wire logic                     bias_shift_enable_switch,
  input wire logic [11:0]              fwd_sample,
  input wire logic [11:0]              rev_sample,
  input wire tx_ctrl_pkg::module_cmd_e module_cmd,
  input wire logic                     tx_off_status,
  input wire logic [7:0]               power_control_level,
  input wire tx_ctrl_pkg::mode_s       mode,
  input wire logic                     pa_bias_class_c,
  input wire logic                     low_gain_fault,
  input wire logic                     foldback_fault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Pin inputs pass a synchroniser first, so each cause must hold for several cycles.
  sequence off_held; tx_off_status[*3]; endsequence
  sequence only_analog; (!analog_carrier_present_n && digital_carrier_present_n)[*8]; endsequence
  sequence no_carrier; (analog_carrier_present_n && digital_carrier_present_n)[*8]; endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer is not zero-wait OKAY");
  off_power_a: assert property (off_held |-> power_control_level == 8'h00)
    else $error("power control not zero while off");
  off_modules_a: assert property (off_held |-> module_cmd != MOD_ON)
    else $error("modules commanded on while off");
  mute_zero_a: assert property (exciter_mute[*8] |-> power_control_level == 8'h00)
    else $error("power control not zero under mute");
  interlock_off_a: assert property (interlock_fault[*8] |-> tx_off_status)
    else $error("broken interlock did not force off");
  overtemp_off_a: assert property (load_overtemp[*8] |-> tx_off_status)
    else $error("load overtemperature did not force off");
  analog_mode_a: assert property (only_analog |-> mode == 3'h4)
    else $error("analog carrier alone did not give analog mode");
  split_mode_a: assert property (no_carrier |-> mode == 3'h1)
    else $error("no carrier did not give digital or split mode");
  mode_onehot_a: assert property ($onehot(mode))
    else $error("mode outputs not one-hot");
  bias_class_a: assert property (pa_bias_class_c |-> $past(mode.analog_only))
    else $error("class C bias outside analog mode");
  bias_off_a: assert property ((!bias_shift_enable_switch)[*8] |-> !pa_bias_class_c)
    else $error("class C bias with shift switch off");
  low_gain_a: assert property ($stable(fwd_sample)[*3] |->
    low_gain_fault == (fwd_sample < FAULT_THRESHOLD))
    else $error("low gain flag disagrees with forward sample");
  foldback_a: assert property ($stable(rev_sample)[*3] |->
    foldback_fault == (rev_sample > FAULT_THRESHOLD))
    else $error("foldback flag disagrees with reverse sample");
endmodule

bind tx_controller tx_checker #(
  .TICK(TICK),
  .PERIOD_TICKS(PERIOD_TICKS),
  .TIMEOUT_TKS(TIMEOUT_TKS)
) chk_u (.mclk, .rst, .hreadyout, .hresp, .interlock_fault, .load_overtemp,
  .analog_carrier_present_n, .digital_carrier_present_n, .exciter_mute,
  .bias_shift_enable_switch, .fwd_sample, .rev_sample, .module_cmd, .tx_off_status,
  .power_control_level, .mode, .pa_bias_class_c, .low_gain_fault, .foldback_fault);

// >>> exciter_model.sv
`timescale 1ns/1ps
module exciter_model (
  input  wire logic mclk,
  input  wire logic want_analog,
  input  wire logic want_digital,
  input  wire logic want_mute,
  output logic      analog_carrier_present_n,
  output logic      digital_carrier_present_n,
  output logic      exciter_mute
);
  // Lines start high so no carrier is claimed before the exciter has run.
  logic an_q = 1'b1;
  logic dg_q = 1'b1;
  logic mu_q = 1'b0;
  always @(posedge mclk) begin
    an_q <= !want_analog;
    dg_q <= !want_digital;
    mu_q <= want_mute;
  end
  assign analog_carrier_present_n  = an_q;
  assign digital_carrier_present_n = dg_q;
  assign exciter_mute              = mu_q;
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tx_ctrl_pkg::*;
  localparam int unsigned TK = 4;
  typedef struct {
    logic an, dg, s;
    logic [11:0] f, r;
    logic [2:0] m;
    logic c, l, b;
  } row_s;
  logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hit;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic ilk = 1'b0, hot = 1'b0, mains = 1'b0, pav = 1'b1, shut = 1'b0, sw = 1'b1;
  logic w_an = 1'b0, w_dg = 1'b0, w_mute = 1'b0;
  logic [11:0] fwd = 12'h0, rev = 12'h0;
  buttons_s btn = '0;
  logic hreadyout, hresp, an_n, dg_n, mute, off_st, rfault, bias, lg, fb;
  logic [7:0] pwr;
  module_cmd_e mcmd;
  mode_s mode;
  int fails = 0, total_checks = 0, cyc = 0;
  row_s rows [5] = '{
    '{1'b1, 1'b0, 1'b1, FAULT_THRESHOLD - 12'h001, FAULT_THRESHOLD + 12'h001, 3'h4, 1, 1, 1},
    '{1'b1, 1'b1, 1'b1, FAULT_THRESHOLD, FAULT_THRESHOLD, 3'h2, 1'b0, 1'b0, 1'b0},
    '{1'b0, 1'b1, 1'b1, 12'hFFF, 12'h000, 3'h1, 1'b0, 1'b0, 1'b0},
    '{1'b0, 1'b0, 1'b1, 12'h000, 12'hFFF, 3'h1, 1'b0, 1'b1, 1'b1},
    '{1'b1, 1'b0, 1'b0, FAULT_THRESHOLD, FAULT_THRESHOLD, 3'h4, 1'b0, 1'b0, 1'b0}};

  exciter_model exc_u (.mclk, .want_analog(w_an), .want_digital(w_dg), .want_mute(w_mute),
    .analog_carrier_present_n(an_n), .digital_carrier_present_n(dg_n), .exciter_mute(mute));
  tx_controller #(.TICK(TK), .PERIOD_TICKS(5), .TIMEOUT_TKS(20)) dut_u (
    .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .interlock_fault(ilk), .load_overtemp(hot),
    .mains_fault(mains), .pa_volts_present(pav), .module_shutdown(shut),
    .analog_carrier_present_n(an_n), .digital_carrier_present_n(dg_n), .exciter_mute(mute),
    .bias_shift_enable_switch(sw), .panel_buttons(btn), .fwd_sample(fwd), .rev_sample(rev),
    .module_cmd(mcmd), .tx_off_status(off_st), .restart_fault(rfault),
    .power_control_level(pwr), .mode, .pa_bias_class_c(bias), .low_gain_fault(lg),
    .foldback_fault(fb));

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // The whole run needs about 1200 cycles; the ceiling leaves a wide margin.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails = fails + 1;
      close_out();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic watch(input int n);
    hit = 1'b0;
    repeat (n) begin
      @(posedge mclk);
      if (mcmd === MOD_RESET) hit = 1'b1;
    end
  endtask

  initial begin
    wt(20);
    rst <= 1'b0;
    wt(1);
    chk_bit(off_st, 1'b1, "off after reset");
    chk_word({24'h0, pwr}, 32'h0, "power after reset");
    chk_word({30'h0, mcmd}, {30'h0, MOD_OFF}, "modules after reset");
    bus(1'b0, IDLE_MAX_OFS, 32'h0);
    chk_word(rd, 32'h0000_0080, "idle max reset");
    bus(1'b0, MAX_HYBRID_OFS, 32'h0);
    chk_word(rd, 32'h0000_00FF, "mode max reset");
    bus(1'b0, 8'h20, 32'h0);
    chk_word(rd, 32'h0, "unmapped read");
    $display("test reset done");
    foreach (rows[i]) begin
      w_an <= rows[i].an;
      w_dg <= rows[i].dg;
      sw <= rows[i].s;
      fwd <= rows[i].f;
      rev <= rows[i].r;
      wt(12);
      chk_word({29'h0, mode}, {29'h0, rows[i].m}, "mode");
      chk_bit(bias, rows[i].c, "bias");
      chk_bit(lg, rows[i].l, "low gain");
      chk_bit(fb, rows[i].b, "foldback");
    end
    $display("test rows done");
    bus(1'b1, CMD_OFS, 32'h5);
    wt(10);
    chk_bit(off_st, 1'b1, "remote ignored when disabled");
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b1, CMD_OFS, 32'h1);
    wt(8);
    chk_word({30'h0, mcmd}, {30'h0, MOD_RESET}, "on pulse resets modules");
    wt(50);
    chk_word({30'h0, mcmd}, {30'h0, MOD_ON}, "modules on");
    chk_bit(off_st, 1'b0, "on");
    repeat (64) bus(1'b1, CMD_OFS, 32'h4);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_word({26'h0, rd[17:12]}, {26'h0, STEP_MAX}, "step stops at top");
    wt(6);
    // Full weight times full mode maximum, over 256.
    chk_word({24'h0, pwr}, 32'h0000_00FE, "full power");
    bus(1'b1, CMD_OFS, 32'h8);
    wt(6);
    chk_bit(pwr < 8'hFE, 1'b1, "lower reduces power");
    btn.raise <= 1'b1;
    wt(40 * TK);
    btn.raise <= 1'b0;
    wt(40 * TK);
    bus(1'b0, STATUS_OFS, 32'h0);
    chk_word({26'h0, rd[17:12]}, {26'h0, STEP_MAX}, "panel raise");
    bus(1'b1, CTRL_OFS, 32'h3);
    wt(8);
    chk_word({24'h0, pwr}, 32'h0, "remote mute");
    bus(1'b1, CTRL_OFS, 32'h1);
    w_mute <= 1'b1;
    wt(10);
    chk_word({24'h0, pwr}, 32'h0, "exciter mute");
    w_mute <= 1'b0;
    bus(1'b1, IDLE_MAX_OFS, 32'h10);
    shut <= 1'b1;
    wt(10);
    chk_word({24'h0, pwr}, 32'h10, "idle clamp");
    shut <= 1'b0;
    bus(1'b1, MAX_ANALOG_OFS, 32'h80);
    wt(8);
    chk_word({24'h0, pwr}, 32'h7F, "mode max");
    $display("test power done");
    pav <= 1'b0;
    watch(40);
    chk_bit(hit, 1'b1, "restart pulse");
    chk_bit(rfault, 1'b0, "no early timeout");
    wt(110);
    chk_bit(rfault, 1'b1, "restart timeout");
    wt(50);
    watch(60);
    chk_bit(hit, 1'b0, "no pulse after timeout");
    mains <= 1'b1;
    bus(1'b1, CMD_OFS, 32'h1);
    wt(10);
    chk_bit(rfault, 1'b0, "on clears timeout");
    wt(60);
    watch(60);
    chk_bit(hit, 1'b0, "no pulse with mains bad");
    mains <= 1'b0;
    pav <= 1'b1;
    $display("test restart done");
    ilk <= 1'b1;
    wt(10);
    chk_bit(off_st, 1'b1, "interlock off");
    ilk <= 1'b0;
    wt(10);
    chk_bit(off_st, 1'b1, "off stays latched");
    bus(1'b1, CMD_OFS, 32'h1);
    wt(10);
    chk_bit(off_st, 1'b0, "on again");
    hot <= 1'b1;
    wt(10);
    chk_bit(off_st, 1'b1, "overtemp off");
    hot <= 1'b0;
    $display("test shutdown done");
    close_out();
  end
endmodule
